// ===== rtl/sld_pkg.sv
// Package for the status indicator driver: register map, field positions,
// reset values, blink timing and the display pattern type.
// Assumes a 200 MHz system clock; all timing is counted in 1 ms ticks.
package sld_pkg;

  // System clock and the base tick of the pattern divider.
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC_DEF = TICK_MS * CLK_MHZ * 1000;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_COND = 8'h00;
  localparam logic [7:0] OFS_VIEW = 8'h04;

  // Condition register fields, written by the module firmware.
  localparam int COND_REGISTERED = 0;
  localparam int COND_REG_BUSY = 1;
  localparam int COND_DOWNLOAD = 2;
  localparam int COND_MSG_PEND = 3;
  localparam int COND_MSG_ACK = 4;
  localparam int COND_PWR_BAD = 5;
  localparam int COND_NET_OK = 6;
  localparam int COND_PANEL_OK = 7;
  localparam int COND_PWR_SAVE = 8;
  localparam int COND_WEB_LSB = 9;
  localparam int COND_MODE_LSB = 11;
  localparam int COND_W = 13;
  localparam logic [12:0] COND_RST = 13'h00C0;

  // Web connection states and operation modes held in the condition register.
  localparam logic [1:0] WEB_NONE = 2'h0;
  localparam logic [1:0] WEB_TRYING = 2'h1;
  localparam logic [1:0] WEB_COMM = 2'h2;
  localparam logic [1:0] WEB_CONNECTED = 2'h3;

  // Pattern divider: an 11 bit count of ms ticks gives a 2048 ms frame.
  localparam int BLINK_W = 11;
  localparam int SLOW_BIT = 9;
  localparam int FAST_BIT = 7;
  localparam int QUICK_BIT = 6;

  // Times in ms: activity and collision stretch, power save frame, debounce.
  localparam int unsigned HOLD_MS = 250;
  localparam int unsigned PWR_FRAME_MS = 15000;
  localparam int unsigned PWR_SHOW_MS = 1000;
  localparam int unsigned DEBOUNCE_MS = 10;

  // Display patterns an indicator can take.
  typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_SLOW, PAT_FAST, PAT_QUICK} sld_pat_t;

  // Debounced switch states.
  typedef enum logic {SW_UP, SW_DOWN} sld_sw_t;

endpackage

// ===== rtl/sld_top.sv
// Status indicator driver: turns module status held in an APB register and
// Ethernet PHY status pins into LED on, off and blink patterns.
// Assumes one 200 MHz clock, an APB master on the same clock, and PHY and
// switch pins that are asynchronous to it.
//
// Notes on behaviour
// - Status, fault and web LEDs can be steady on, steady off, fast blink or slow blink.
// - Green LED steady on while the module is not registered.
// - Green LED off once the module is registered.
// - Green LED fast blinks during a remote download session.
// - Registration in progress slow blinks green and yellow in phase.
// - Yellow LED steady on while a message waits to be sent.
// - Yellow fast blinks awaiting acknowledge, quick periodic blink when normal.
// - Yellow alone slow blinks when idle with power abnormal.
// - Red on with no network but panel fine, off with no fault.
// - Red slow blinks when the panel keypad bus link is lost.
// - Red fast blinks when network and panel link are both lost.
// - Collision LED blinks on detected collisions, otherwise off.
// - First network green LED on at 100 Mb/s, off at 10 Mb/s.
// - Link LED on with link, off without, fast blink on activity.
// - With power saving enabled and the switch released, LEDs show only once every 15 seconds.
// - Mode on LEDs 2 and 3: off/off, on/off, off/on, on/on.
// - LED 4 shows web state; LEDs 5 and 6 stay unused.
// - Switch held forces LED 1 off and shows mode and web state.
`timescale 1ns/1ps

module sld_top import sld_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ethernet PHY status pins and the mode switch, all asynchronous.
  input wire logic phy_collision,
  input wire logic phy_speed100,
  input wire logic phy_link,
  input wire logic phy_activity,
  input wire logic mode_sw_n,
  // Front panel LEDs.
  output logic led_status,
  output logic led_message,
  output logic led_fault,
  // Network LEDs.
  output logic led_collision,
  output logic led_speed,
  output logic led_link,
  // Mode and status row, bit 0 is LED 1.
  output logic [5:0] led_row
);

  localparam int TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // Level of a pattern for the current divider phase.
  function automatic logic pat_level(input sld_pat_t p, input logic s, input logic f,
                                     input logic q);
    case (p)
      PAT_ON: pat_level = 1'b1;
      PAT_SLOW: pat_level = s;
      PAT_FAST: pat_level = f;
      PAT_QUICK: pat_level = q;
      default: pat_level = 1'b0;
    endcase
  endfunction

  logic [COND_W-1:0] cond;
  logic [TCW-1:0] tick_cnt;
  logic tick;
  logic [BLINK_W-1:0] blink_cnt;
  logic slow_on;
  logic fast_on;
  logic quick_on;
  logic [13:0] pwr_cnt;
  logic show;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pin_q;
  logic [7:0] coll_hold;
  logic [7:0] act_hold;
  sld_sw_t sw_state;
  logic [3:0] deb_cnt;
  logic sw_held;
  sld_pat_t pat_green;
  sld_pat_t pat_yellow;
  sld_pat_t pat_red;
  sld_pat_t pat_web;
  logic apb_access;
  logic apb_done;

  // APB: the access phase is answered one cycle after it starts.
  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= apb_access && !pready && (paddr != OFS_COND) && (paddr != OFS_VIEW);
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          OFS_COND: prdata <= {19'h0_0000, cond};
          OFS_VIEW: prdata <= {15'h0000, sw_held, pin_q[3:0], led_row, led_link, led_speed,
                               led_collision, led_fault, led_message, led_status};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Condition register; a write lands only on the completing edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond <= COND_RST;
    end else if (apb_done && pwrite && (paddr == OFS_COND)) begin
      cond <= pwdata[COND_W-1:0];
    end
  end

  // Base 1 ms tick. Long times are counted in ticks so one parameter shortens all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TCW'(TICK_CYCLES - 1));
      if (tick_cnt == TCW'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  // One free running pattern counter, so equal patterns are always in phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= '0;
    end else if (tick) begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  assign slow_on = !blink_cnt[SLOW_BIT];
  assign fast_on = !blink_cnt[FAST_BIT];
  assign quick_on = (blink_cnt[BLINK_W-1:QUICK_BIT] == '0);

  // Power save frame: LEDs show for a short window at the start of each frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt <= '0;
    end else if (tick) begin
      if (pwr_cnt == 14'(PWR_FRAME_MS - 1)) begin
        pwr_cnt <= '0;
      end else begin
        pwr_cnt <= pwr_cnt + 1'b1;
      end
    end
  end

  assign show = !cond[COND_PWR_SAVE] || (pwr_cnt < 14'(PWR_SHOW_MS));

  // Pin synchronisers; a change counts only once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h10;
      sync2 <= 5'h10;
      sync3 <= 5'h10;
      pin_q <= 5'h10;
    end else begin
      sync1 <= {mode_sw_n, phy_activity, phy_link, phy_speed100, phy_collision};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 5; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_q[i] <= sync3[i];
        end
      end
    end
  end

  // Collisions and activity are short; stretch them so a blink is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_hold <= '0;
      act_hold <= '0;
    end else begin
      if (pin_q[0]) begin
        coll_hold <= 8'(HOLD_MS);
      end else if (tick && coll_hold != '0) begin
        coll_hold <= coll_hold - 1'b1;
      end
      if (pin_q[3]) begin
        act_hold <= 8'(HOLD_MS);
      end else if (tick && act_hold != '0) begin
        act_hold <= act_hold - 1'b1;
      end
    end
  end

  // Switch debounce: the new level must hold for a full debounce time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state <= SW_UP;
      deb_cnt <= '0;
    end else begin
      case (sw_state)
        SW_UP: begin
          if (pin_q[4]) begin
            deb_cnt <= '0;
          end else if (tick) begin
            if (deb_cnt == 4'(DEBOUNCE_MS - 1)) begin
              sw_state <= SW_DOWN;
              deb_cnt <= '0;
            end else begin
              deb_cnt <= deb_cnt + 1'b1;
            end
          end
        end
        SW_DOWN: begin
          if (!pin_q[4]) begin
            deb_cnt <= '0;
          end else if (tick) begin
            if (deb_cnt == 4'(DEBOUNCE_MS - 1)) begin
              sw_state <= SW_UP;
              deb_cnt <= '0;
            end else begin
              deb_cnt <= deb_cnt + 1'b1;
            end
          end
        end
        default: begin
          sw_state <= SW_UP;
          deb_cnt <= '0;
        end
      endcase
    end
  end

  assign sw_held = (sw_state == SW_DOWN);

  // Pattern selection for the front panel, highest priority first.
  always_comb begin
    if (cond[COND_DOWNLOAD]) begin
      pat_green = PAT_FAST;
    end else if (cond[COND_REG_BUSY]) begin
      pat_green = PAT_SLOW;
    end else if (!cond[COND_REGISTERED]) begin
      pat_green = PAT_ON;
    end else begin
      pat_green = PAT_OFF;
    end
    if (cond[COND_REG_BUSY]) begin
      pat_yellow = PAT_SLOW;
    end else if (cond[COND_MSG_PEND]) begin
      pat_yellow = PAT_ON;
    end else if (cond[COND_MSG_ACK]) begin
      pat_yellow = PAT_FAST;
    end else if (cond[COND_PWR_BAD]) begin
      pat_yellow = PAT_SLOW;
    end else begin
      pat_yellow = PAT_QUICK;
    end
    if (!cond[COND_NET_OK] && !cond[COND_PANEL_OK]) begin
      pat_red = PAT_FAST;
    end else if (!cond[COND_PANEL_OK]) begin
      pat_red = PAT_SLOW;
    end else if (!cond[COND_NET_OK]) begin
      pat_red = PAT_ON;
    end else begin
      pat_red = PAT_OFF;
    end
    case (cond[COND_WEB_LSB +: 2])
      WEB_TRYING: pat_web = PAT_SLOW;
      WEB_COMM: pat_web = PAT_FAST;
      WEB_CONNECTED: pat_web = PAT_ON;
      default: pat_web = PAT_OFF;
    endcase
  end

  // Front panel LEDs, blanked outside the power save window.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_status <= 1'b0;
      led_message <= 1'b0;
      led_fault <= 1'b0;
    end else begin
      led_status <= show && pat_level(pat_green, slow_on, fast_on, quick_on);
      led_message <= show && pat_level(pat_yellow, slow_on, fast_on, quick_on);
      led_fault <= show && pat_level(pat_red, slow_on, fast_on, quick_on);
    end
  end

  // Network LEDs follow the synchronised PHY pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_collision <= 1'b0;
      led_speed <= 1'b0;
      led_link <= 1'b0;
    end else begin
      led_collision <= show && (coll_hold != '0) && fast_on;
      led_speed <= show && pin_q[1];
      led_link <= show && pin_q[2] && ((act_hold == '0) || fast_on);
    end
  end

  // Mode row: mirrors the fault LED normally, shows mode and web while held.
  // Holding the switch bypasses power save, since the user is looking.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_row <= 6'h00;
    end else if (sw_held) begin
      led_row[0] <= 1'b0;
      led_row[1] <= cond[COND_MODE_LSB];
      led_row[2] <= cond[COND_MODE_LSB + 1];
      led_row[3] <= pat_level(pat_web, slow_on, fast_on, quick_on);
      led_row[5:4] <= 2'h0;
    end else begin
      led_row <= {5'h00, show && pat_level(pat_red, slow_on, fast_on, quick_on)};
    end
  end

  // Checks on the indicator mapping.
  chk_green_unreg: assert property (@(posedge clk) disable iff (!rst_n)
    show && !cond[COND_REGISTERED] && !cond[COND_DOWNLOAD] && !cond[COND_REG_BUSY]
    |=> led_status)
    else $error("Green LED not on while unregistered.");

  chk_green_reg_off: assert property (@(posedge clk) disable iff (!rst_n)
    cond[COND_REGISTERED] && !cond[COND_DOWNLOAD] && !cond[COND_REG_BUSY] |=> !led_status)
    else $error("Green LED not off while registered.");

  chk_green_download: assert property (@(posedge clk) disable iff (!rst_n)
    show && cond[COND_DOWNLOAD] |=> led_status == $past(fast_on))
    else $error("Green LED not fast blinking during download.");

  chk_reg_unison: assert property (@(posedge clk) disable iff (!rst_n)
    cond[COND_REG_BUSY] && !cond[COND_DOWNLOAD] |=> led_status == led_message)
    else $error("Green and yellow out of step during registration.");

  chk_msg_pending: assert property (@(posedge clk) disable iff (!rst_n)
    show && !cond[COND_REG_BUSY] && cond[COND_MSG_PEND] ##1 $stable(cond) |-> led_message)
    else $error("Yellow LED not on with message pending.");

  chk_fault_both: assert property (@(posedge clk) disable iff (!rst_n)
    show && !cond[COND_NET_OK] && !cond[COND_PANEL_OK] |=> led_fault == $past(fast_on))
    else $error("Red LED not fast blinking with both links lost.");

  chk_speed_led: assert property (@(posedge clk) disable iff (!rst_n)
    !cond[COND_PWR_SAVE] |=> led_speed == $past(pin_q[1]))
    else $error("Speed LED does not follow link speed.");

  chk_power_save: assert property (@(posedge clk) disable iff (!rst_n)
    !show |=> !led_status && !led_message && !led_fault && !led_link && !led_speed)
    else $error("LEDs lit outside the power save window.");

  chk_row_mode: assert property (@(posedge clk) disable iff (!rst_n)
    sw_held |=> !led_row[0] && led_row[2:1] == $past(cond[COND_MODE_LSB +: 2])
      && led_row[5:4] == 2'h0)
    else $error("Mode row wrong while switch held.");

  chk_switch_stable: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sw_held) |-> $past(tick) && $past(deb_cnt) == 4'(DEBOUNCE_MS - 1))
    else $error("Switch state changed before debounce time.");

  chk_apb_wait: assert property (@(posedge clk) disable iff (!rst_n)
    apb_access && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access.");

  // Main scenarios worth seeing.
  cov_download: cover property (@(posedge clk) disable iff (!rst_n)
    cond[COND_DOWNLOAD] ##1 $rose(led_status));
  cov_switch_held: cover property (@(posedge clk) disable iff (!rst_n) $rose(sw_held));
  cov_collision: cover property (@(posedge clk) disable iff (!rst_n) $rose(led_collision));
  cov_power_save: cover property (@(posedge clk) disable iff (!rst_n)
    cond[COND_PWR_SAVE] && $fell(show));

endmodule // sld_top

// ===== tb/sld_switch_model.sv
// Behavioural model of the mode and status push switch.
// Assumes the bench raises press by non-blocking assignment at a clock edge.
`timescale 1ns/1ps

module sld_switch_model (
  // Clock and push request.
  input wire logic clk,
  input wire logic press,
  // Switch contact, low while pressed.
  output logic mode_sw_n
);
  logic last = 1'b0;
  logic contact = 1'b1;
  int bounce = 0;

  // One process owns the contact level; the port only mirrors it.
  assign mode_sw_n = contact;

  // Every change chatters for a few cycles before settling, as a real contact does.
  always @(posedge clk) begin
    if (press !== last) begin
      last <= press;
      bounce <= 7;
    end else if (bounce > 0) begin
      bounce <= bounce - 1;
      contact <= (bounce == 1) ? ~press : ~contact;
    end
  end
endmodule // sld_switch_model

// ===== tb/sld_top_tb_top.sv
// Self-checking bench: drives APB, PHY pins and the switch, classifies LED patterns.
// Assumes a short tick so that one ms is TC clock cycles.
`timescale 1ns/1ps

module sld_top_tb_top import sld_pkg::*;;
  localparam int TC = 4;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, press, e;
  logic coll = 1'b0, act = 1'b0, spd, lnk, sw_n, rnd_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic l_st, l_msg, l_flt, l_col, l_spd, l_lnk;
  logic [5:0] row;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'd35980;
  int cyc = 0;

  sld_top #(.TICK_CYCLES(TC)) sld_top_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phy_collision(coll), .phy_speed100(spd),
    .phy_link(lnk), .phy_activity(act), .mode_sw_n(sw_n), .led_status(l_st),
    .led_message(l_msg), .led_fault(l_flt), .led_collision(l_col), .led_speed(l_spd),
    .led_link(l_lnk), .led_row(row));

  sld_switch_model sld_switch_model_i (.clk(clk), .press(press), .mode_sw_n(sw_n));

  // Free running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs_next(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Cycles since reset release; the power save frame starts counting there.
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  // Random collision and activity traffic, the only driver of those pins after time zero.
  always @(posedge clk) begin
    seed <= xs_next(seed);
    coll <= rnd_on & seed[3];
    act <= rnd_on & seed[7];
  end

  task automatic check(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, x);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reference model of the display priorities.
  function automatic sld_pat_t lvl(logic b);
    return b ? PAT_ON : PAT_OFF;
  endfunction
  function automatic sld_pat_t m_st(logic [12:0] c);
    if (c[COND_DOWNLOAD]) return PAT_FAST;
    if (c[COND_REG_BUSY]) return PAT_SLOW;
    return lvl(!c[COND_REGISTERED]);
  endfunction
  function automatic sld_pat_t m_msg(logic [12:0] c);
    if (c[COND_REG_BUSY]) return PAT_SLOW;
    if (c[COND_MSG_PEND]) return PAT_ON;
    if (c[COND_MSG_ACK]) return PAT_FAST;
    return c[COND_PWR_BAD] ? PAT_SLOW : PAT_QUICK;
  endfunction
  function automatic sld_pat_t m_flt(logic [12:0] c);
    if (!c[COND_NET_OK] && !c[COND_PANEL_OK]) return PAT_FAST;
    if (!c[COND_PANEL_OK]) return PAT_SLOW;
    return lvl(!c[COND_NET_OK]);
  endfunction
  function automatic sld_pat_t m_web(logic [1:0] w);
    case (w)
      WEB_NONE: return PAT_OFF;
      WEB_TRYING: return PAT_SLOW;
      WEB_COMM: return PAT_FAST;
      default: return PAT_ON;
    endcase
  endfunction

  // Edge count and lit time over a window tell the pattern apart.
  function automatic sld_pat_t cls(int hi, int ed, int n);
    if (ed == 0) return lvl(hi > 0);
    if (hi * 16 < n) return PAT_QUICK;
    return (ed * 192 * TC >= n) ? PAT_FAST : PAT_SLOW;
  endfunction

  // Program a condition, settle past the stretch time, then watch all twelve LEDs.
  task automatic run_case(input logic [12:0] c, input logic [2:0] ph, input logic sw,
                          input int ms);
    sld_pat_t x [12];
    int hi [12];
    int ed [12];
    logic [11:0] v, pv;
    int df, n;
    apb(1'b1, OFS_COND, {19'h0, c}, rd, e);
    rnd_on <= ph[2];
    spd <= ph[1];
    lnk <= ph[0];
    press <= sw;
    repeat (300 * TC) @(posedge clk);
    x[0] = m_st(c);
    x[1] = m_msg(c);
    x[2] = m_flt(c);
    x[3] = ph[2] ? PAT_FAST : PAT_OFF;
    x[4] = lvl(ph[1]);
    x[5] = ph[2] ? PAT_FAST : lvl(ph[0]);
    x[6] = sw ? PAT_OFF : x[2];
    x[7] = sw ? lvl(c[COND_MODE_LSB]) : PAT_OFF;
    x[8] = sw ? lvl(c[COND_MODE_LSB + 1]) : PAT_OFF;
    x[9] = sw ? m_web(c[COND_WEB_LSB +: 2]) : PAT_OFF;
    x[10] = PAT_OFF;
    x[11] = PAT_OFF;
    df = 0;
    n = ms * TC;
    for (int i = 0; i < 12; i++) begin
      hi[i] = 0;
      ed[i] = 0;
    end
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      v = {row, l_lnk, l_spd, l_col, l_flt, l_msg, l_st};
      for (int i = 0; i < 12; i++) begin
        if (v[i] === 1'b1) hi[i]++;
        if (k > 0 && v[i] !== pv[i]) ed[i]++;
      end
      if (v[0] !== v[1]) df++;
      pv = v;
    end
    for (int i = 0; i < 12; i++) check(cls(hi[i], ed[i], n), x[i]);
    if (c[COND_REG_BUSY]) check(df, 0);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    int hi, bad, pos;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    press = 1'b0;
    rnd_on = 1'b0;
    spd = 1'b0;
    lnk = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_COND, 32'h0, rd, e);
    check(e, 1'b0);
    check(rd, {19'h0, COND_RST});
    apb(1'b1, OFS_COND, 32'hFFFFFFFF, rd, e);
    apb(1'b0, OFS_COND, 32'h0, rd, e);
    check(rd, 32'h00001FFF);
    apb(1'b1, 8'h08, 32'h0, rd, e);
    check(e, 1'b1);
    apb(1'b0, 8'h08, 32'h0, rd, e);
    check(e, 1'b1);
    check(rd, 32'h0);
    press <= 1'b1;
    repeat (5 * TC) @(posedge clk);
    press <= 1'b0;
    repeat (30 * TC) @(posedge clk);
    apb(1'b0, OFS_VIEW, 32'h0, rd, e);
    check(rd[16], 1'b0);
    press <= 1'b1;
    repeat (30 * TC) @(posedge clk);
    apb(1'b0, OFS_VIEW, 32'h0, rd, e);
    check(rd[16], 1'b1);
    // Power save early, so the window holds the end of the first show period and blanking after it.
    apb(1'b1, OFS_COND, 32'h000001C0, rd, e);
    press <= 1'b0;
    repeat (300 * TC) @(posedge clk);
    hi = 0;
    bad = 0;
    for (int k = 0; k < 4000 * TC; k++) begin
      @(posedge clk);
      #1;
      if (l_st === 1'b1) hi++;
      pos = (cyc / TC) % PWR_FRAME_MS;
      if ((pos > 2 && pos < PWR_SHOW_MS - 2) || (pos > PWR_SHOW_MS + 2 && pos < PWR_FRAME_MS - 2)) begin
        if (l_st !== (pos < PWR_SHOW_MS)) bad++;
      end
    end
    check(hi > 1000 * TC + 8, 1'b0);
    check(hi > 100 * TC, 1'b1);
    check(bad, 0);
    run_case(13'h00C0, 3'b000, 1'b0, 2048);
    run_case(13'h0002, 3'b011, 1'b0, 2048);
    run_case(13'h004C, 3'b101, 1'b0, 2048);
    run_case(13'h0091, 3'b000, 1'b0, 2048);
    run_case(13'h00E1, 3'b000, 1'b0, 2048);
    for (int k = 0; k < 4; k++) begin
      run_case(13'(13'h00C9 | (k << 9) | (k << 11)), 3'b000, 1'b1, 1024);
    end
    finish_test();
  end
endmodule // sld_top_tb_top
